// file: flash_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_bus_cycle
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in_sync,
  output logic done,
  output logic [15:0] rdata,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe
);
  localparam logic [3:0] ACC = 4'(`ACC_CYCLES + 2);
  localparam logic [3:0] WP = 4'(`WP_CYCLES);
  logic [3:0] cnt_reg;
  logic busy_reg;
  logic wr_reg;
  wire last = (cnt_reg == 4'h1);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      addr_out <= '0;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_reg && start) begin
        busy_reg <= 1'b1;
        wr_reg <= is_write;
        cnt_reg <= is_write ? WP : ACC;
        addr_out <= addr;
        dq_out <= wdata;
        dq_oe <= is_write;
        chip_select_n <= 1'b0;
        read_strobe_n <= is_write;
        write_strobe_n <= !is_write;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (last) begin
          // strobes rise together; data held one more cycle for hold time
          busy_reg <= 1'b0;
          done <= 1'b1;
          chip_select_n <= 1'b1;
          read_strobe_n <= 1'b1;
          write_strobe_n <= 1'b1;
          if (!wr_reg) begin
            rdata <= dq_in_sync;
          end
        end
      end else begin
        dq_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: flash_cmd_pkg.sv
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_autosel,
    op_read_id,
    op_reset,
    op_crc_chip,
    op_crc_range,
    op_suspend
  } op_e;
  typedef enum logic [2:0] {
    rd_manuf,
    rd_dev1,
    rd_dev2,
    rd_dev3,
    rd_prot,
    rd_extlock
  } id_sel_e;
endpackage

// file: flash_cmd_regs.svh
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH
`define UNLOCK1_ADDR_W 8'h55
`define UNLOCK1_ADDR_HI 4'h5
`define UNLOCK2_ADDR_W 12'h2aa
`define UNLOCK1_ADDR_B 12'haaa
`define UNLOCK1_DATA 16'h00aa
`define UNLOCK2_DATA 16'h0055
`define EXT_FUNC_CODE 16'h00eb
`define CRC_SUBOP_CODE 16'h0027
`define RANGE_COUNT_W 16'h000a
`define RANGE_COUNT_B 16'h0015
`define CHIP_COUNT_W 16'h0004
`define CHIP_COUNT_B 16'h0009
`define RANGE_OPT_W 16'hfffe
`define CHIP_OPT_W 16'hffff
`define OPT_LO_RANGE_B 16'h00fe
`define OPT_FF_B 16'h00ff
`define CONFIRM_CODE 16'h0029
`define AUTOSEL_CODE 16'h0090
`define RESET_CODE 16'h00f0
`define SUSPEND_CODE 16'h00b0
`define PROT_OFFSET 4'h2
`define EXTLOCK_OFFSET 4'h3
`define DEVID1_OFFSET 4'h1
`define DEVID2_OFFSET 4'he
`define DEVID3_OFFSET 4'hf
`define CRC_WORD_BASE 4'h1
`define RANGE_START_OFS 4'h5
`define RANGE_STOP_OFS 4'h8
`define RANGE_RSVD1_OFS 4'h7
`define RANGE_RSVD2_OFS 4'ha
`define POLL_DONE_BIT 7
`define POLL_ERR_BIT 5
`define TACC_NS 100
`define TWP_NS 50
`define CLK_NS 20
`define ACC_CYCLES (((`TACC_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define WP_CYCLES (((`TWP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

// file: flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  input wire logic mclk,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [25:0] addr_out,
  input wire logic [15:0] dq_out,
  input wire logic prog_busy,
  input wire logic slow,
  input wire logic byte_mode,
  input wire logic byte_lsb_address,
  output logic [15:0] dq_in,
  output logic ready_busy_pin
);
  logic [15:0] w [0:16];
  logic [15:0] ld, rd;
  logic [25:0] la;
  logic lw = 0, idmode = 0, susp = 0, stat = 0, busy = 0, fail = 0, rng = 0, ok, rsv;
  int n = 0, last, cnt = 0, k;
  wire [25:0] a = addr_out;
  wire [25:0] ua = byte_mode ? 26'haaa : 26'h555;
  wire [15:0] arr = {{a[6:0], 1'b1} ^ 8'h5a, {a[6:0], 1'b0} ^ 8'h5a};
  // ids arbitrary
  wire [15:0] idv = a[15:0] == 16'h2 ? {15'h0, a[16]} : a == 26'h3 ? 16'h0009 : a == 26'h0 ? 16'h00c1 :
    a == 26'h1 ? 16'h1a01 : a == 26'he ? 16'h1a02 : a == 26'hf ? 16'h1a03 : 16'h0;
  function automatic logic [63:0] crc(input int s, input int e);
    logic [63:0] c;
    logic [7:0] b;
    c = '0;
    for (int i = s; i <= e; i++) begin
      b = 8'(i) ^ 8'h5a;
      // reflected polynomial, so bits go in lsb first
      for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ b[k]) ? 64'hc96c5795d7870f42 : 64'h0);
    end
    return c;
  endfunction
  assign ready_busy_pin = !busy && !(prog_busy && !susp);
  assign rd = stat ? {8'h0, !busy, 1'b0, fail && !busy, 5'h0} : idmode ? idv : arr;
  // inverse when released so a stale value never passes
  assign dq_in = (!chip_select_n && !read_strobe_n) ? rd : ~rd;
  always @(posedge mclk) begin
    if (cnt > 0) begin
      cnt--;
      busy = cnt > 0;
    end
    if (!chip_select_n && !write_strobe_n) begin
      la = byte_mode ? {addr_out[24:0], byte_lsb_address} : addr_out;
      ld = dq_out;
      lw = 1;
    end else if (lw) begin
      lw = 0;
      stat = 0;
      // byte mode: one byte a write, each expected word low byte then high byte
      last = byte_mode ? (rng ? 27 : 15) : (rng ? 16 : 10);
      rsv = rng && (byte_mode ? (n == 19 || n == 20 || n == 25 || n == 26) : (n == 12 || n == 15));
      ok = la == (n == 0 ? ua : n == 1 ? (byte_mode ? 26'h555 : 26'h2aa) : (n < 6 || n == last) ? 26'h0 :
        26'(n - 5));
      if (n == 0 && ld == 16'h00f0) begin
        idmode = 0;
      end else if (n == 0 && ld == 16'h00b0) begin
        susp = 1;
      end else if (n == 2 && la == ua && ld == 16'h0090) begin
        idmode = ready_busy_pin;
        n = 0;
      end else if (n == 2 && la == ua && ld == 16'h00f0) begin
        idmode = 0;
        n = 0;
      end else begin
        case (n)
          0: ok &= ld == 16'h00aa;
          1: ok &= ld == 16'h0055;
          2: ok &= ld == 16'h00eb;
          3: ok &= ld == 16'h0027;
          4: begin
            rng = ld == (byte_mode ? 16'h0015 : 16'h000a);
            ok &= rng || ld == (byte_mode ? 16'h0009 : 16'h0004);
          end
          5: ok &= ld == (byte_mode ? (rng ? 16'h00fe : 16'h00ff) : (rng ? 16'hfffe : 16'hffff));
          default: ok &= n == last ? ld == 16'h0029 :
            (byte_mode && n == 6) ? ld == 16'h00ff : !rsv || ld == 16'h0;
        endcase
        if (byte_mode && n >= 7) begin
          k = (n - 5) / 2 + 5;
          w[k] = n[0] ? {8'h00, ld[7:0]} : {ld[7:0], w[k][7:0]};
        end else begin
          w[n] = ld;
        end
        n = ok ? n + 1 : 0;
        if (ok && n > last) begin
          n = 0;
          if (!rng || {w[14], w[13]} > {w[11], w[10]}) begin
            fail = crc(rng ? {w[11], w[10]} : 0, rng ? {w[14], w[13]} : 63) !== {w[9], w[8], w[7], w[6]};
            stat = 1;
            busy = 1;
            cnt = slow ? 2000 : 3;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: flash_id_crc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module flash_id_crc_ctrl
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 26,
  parameter int POLL_LIMIT = 65535
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire op_e cmd_op,
  input wire id_sel_e cmd_id_sel,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [31:0] cmd_start_addr,
  input wire logic [31:0] cmd_stop_addr,
  input wire logic [63:0] cmd_expected_crc,
  input wire logic byte_mode,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic resp_crc_fail,
  output logic resp_refused,
  output logic resp_timeout,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic byte_lsb_address,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in,
  input wire logic ready_busy_pin
);
  typedef enum logic [2:0] {s_idle, s_seq, s_poll, s_resp} state_e;
  state_e state_reg;
  logic [4:0] step_reg;
  logic go_reg;
  op_e op_reg;
  id_sel_e sel_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [31:0] start_reg, stop_reg;
  logic [63:0] crc_reg;
  logic bmode_reg;
  logic [15:0] dq_s1, dq_s2;
  logic rb_s1, rb_s2;
  logic [31:0] poll_cnt_reg;
  logic cyc_start_reg;
  logic cyc_wr_reg;
  logic [ADDR_W:0] cyc_addr_reg;
  logic [15:0] cyc_data_reg;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [ADDR_W-1:0] bus_addr;
  // step decoder: one bus cycle per step; address carries byte lane in bit 0
  function automatic logic [ADDR_W+16:0] step_word(input op_e op, input logic [4:0] s, input logic bm,
      input logic [63:0] crc, input logic [31:0] sa, input logic [31:0] ea, input logic [ADDR_W-1:0] idaddr,
      input id_sel_e sel);
    logic [ADDR_W:0] a;
    logic [15:0] d;
    logic [3:0] w;
    logic hi;
    logic [15:0] crcw;
    a = '0;
    d = 16'h0000;
    w = 4'h0;
    hi = 1'b0;
    crcw = 16'h0000;
    if (s == 5'd0) begin
      a = bm ? (ADDR_W+1)'(`UNLOCK1_ADDR_B) : (ADDR_W+1)'({`UNLOCK1_ADDR_HI, `UNLOCK1_ADDR_W, 1'b0});
      d = `UNLOCK1_DATA;
    end else if (s == 5'd1) begin
      a = bm ? (ADDR_W+1)'({`UNLOCK1_ADDR_HI, `UNLOCK1_ADDR_W}) : (ADDR_W+1)'({`UNLOCK2_ADDR_W, 1'b0});
      d = `UNLOCK2_DATA;
    end else if (op == op_autosel || op == op_reset || op == op_suspend) begin
      d = (op == op_autosel) ? `AUTOSEL_CODE : (op == op_reset) ? `RESET_CODE : `SUSPEND_CODE;
      a = bm ? (ADDR_W+1)'(`UNLOCK1_ADDR_B) : (ADDR_W+1)'({`UNLOCK1_ADDR_HI, `UNLOCK1_ADDR_W, 1'b0});
    end else if (op == op_read_id) begin
      case (sel)
        rd_manuf: w = 4'h0;
        rd_dev1: w = `DEVID1_OFFSET;
        rd_dev2: w = `DEVID2_OFFSET;
        rd_dev3: w = `DEVID3_OFFSET;
        rd_prot: w = `PROT_OFFSET;
        default: w = `EXTLOCK_OFFSET;
      endcase
      // protection read keeps only the block base; middle address bits forced low
      a = (sel == rd_prot) ? {idaddr[ADDR_W-1:16], 12'h000, w, 1'b0} : (ADDR_W+1)'({w, 1'b0});
    end else if (s == 5'd2) begin
      d = `EXT_FUNC_CODE;
    end else if (s == 5'd3) begin
      d = `CRC_SUBOP_CODE;
    end else if (s == 5'd4) begin
      if (op == op_crc_range) begin
        d = bm ? `RANGE_COUNT_B : `RANGE_COUNT_W;
      end else begin
        d = bm ? `CHIP_COUNT_B : `CHIP_COUNT_W;
      end
    end else if (s == 5'd5) begin
      d = (op == op_crc_range) ? (bm ? `OPT_LO_RANGE_B : `RANGE_OPT_W) : (bm ? `OPT_FF_B : `CHIP_OPT_W);
    end else if (bm && s == 5'd6) begin
      a = (ADDR_W+1)'(1);
      d = `OPT_FF_B;
    end else if (s == 5'd30) begin
      d = `CONFIRM_CODE;
    end else begin
      // word offsets from 1; in byte mode two lanes per word, low first
      w = bm ? 4'(((s - 5'd7) >> 1) + 5'd1) : 4'(s - 5'd5);
      hi = bm ? ~s[0] : 1'b0;
      case (w)
        4'h1: crcw = crc[15:0];
        4'h2: crcw = crc[31:16];
        4'h3: crcw = crc[47:32];
        4'h4: crcw = crc[63:48];
        `RANGE_START_OFS: crcw = sa[15:0];
        4'h6: crcw = sa[31:16];
        `RANGE_STOP_OFS: crcw = ea[15:0];
        4'h9: crcw = ea[31:16];
        default: crcw = 16'h0000;
      endcase
      a = bm ? (ADDR_W+1)'({w, hi}) : (ADDR_W+1)'({w, 1'b0});
      d = bm ? (hi ? {8'h00, crcw[15:8]} : {8'h00, crcw[7:0]}) : crcw;
    end
    return {a, d};
  endfunction
  wire [ADDR_W+16:0] step_bus = step_word(op_reg, step_reg, bmode_reg, crc_reg, start_reg, stop_reg,
      base_reg, sel_reg);
  wire [4:0] crc_words_end = (op_reg == op_crc_range) ? 5'd10 : 5'd4;
  wire [4:0] crc_last = bmode_reg ? 5'(6 + 2 * crc_words_end) : 5'(5 + crc_words_end);
  wire [4:0] next_step = (step_reg == crc_last && (op_reg == op_crc_chip || op_reg == op_crc_range)) ? 5'd30 :
      step_reg + 5'd1;
  wire is_crc = (op_reg == op_crc_chip) || (op_reg == op_crc_range);
  wire range_bad = (cmd_op == op_crc_range) && (cmd_stop_addr <= cmd_start_addr);
  wire busy_block = (cmd_op == op_autosel) && !rb_s2;
  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .mclk(mclk),
    .rst(rst),
    .start(cyc_start_reg),
    .is_write(cyc_wr_reg),
    .addr(cyc_addr_reg[ADDR_W:1]),
    .wdata(cyc_data_reg),
    .dq_in_sync(dq_s2),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .addr_out(bus_addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );
  assign addr_out = bus_addr;
  logic lsb_reg;
  assign byte_lsb_address = lsb_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_pin;
      rb_s2 <= rb_s1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= s_idle;
      step_reg <= 5'd0;
      go_reg <= 1'b0;
      op_reg <= op_none;
      sel_reg <= rd_manuf;
      base_reg <= '0;
      start_reg <= 32'h0;
      stop_reg <= 32'h0;
      crc_reg <= 64'h0;
      bmode_reg <= 1'b0;
      poll_cnt_reg <= 32'h0;
      cyc_start_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      cyc_addr_reg <= '0;
      cyc_data_reg <= 16'h0000;
      lsb_reg <= 1'b0;
      cmd_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= 16'h0000;
      resp_crc_fail <= 1'b0;
      resp_refused <= 1'b0;
      resp_timeout <= 1'b0;
    end else begin
      cyc_start_reg <= 1'b0;
      resp_valid <= 1'b0;
      case (state_reg)
        s_idle: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_reg <= cmd_op;
            sel_reg <= cmd_id_sel;
            base_reg <= cmd_addr;
            start_reg <= cmd_start_addr;
            stop_reg <= cmd_stop_addr;
            crc_reg <= cmd_expected_crc;
            bmode_reg <= byte_mode;
            resp_crc_fail <= 1'b0;
            resp_timeout <= 1'b0;
            resp_refused <= 1'b0;
            // busy part would refuse query entry; range with stop<=start does nothing
            if (busy_block || range_bad || cmd_op == op_none) begin
              resp_refused <= 1'b1;
              state_reg <= s_resp;
            end else begin
              step_reg <= (cmd_op == op_read_id) ? 5'd2 : (cmd_op == op_suspend) ? 5'd2 : 5'd0;
              state_reg <= s_seq;
              go_reg <= 1'b1;
            end
          end
        end
        s_seq: begin
          // load and launch together so no cycle starts on the previous step's word
          if (go_reg) begin
            go_reg <= 1'b0;
            cyc_start_reg <= 1'b1;
            cyc_wr_reg <= (op_reg != op_read_id);
            cyc_addr_reg <= step_bus[ADDR_W+16:16];
            cyc_data_reg <= step_bus[15:0];
            lsb_reg <= step_bus[16] & bmode_reg;
          end
          if (cyc_done) begin
            if (op_reg == op_read_id) begin
              resp_data <= cyc_rdata;
              state_reg <= s_resp;
            end else if (step_reg == 5'd30) begin
              poll_cnt_reg <= 32'h0;
              state_reg <= s_poll;
              cyc_wr_reg <= 1'b0;
              cyc_addr_reg <= '0;
              lsb_reg <= 1'b0;
              cyc_start_reg <= 1'b1;
            end else if (!is_crc && step_reg >= 5'd2) begin
              state_reg <= s_resp;
            end else begin
              step_reg <= next_step;
              go_reg <= 1'b1;
            end
          end
        end
        s_poll: begin
          if (cyc_done) begin
            poll_cnt_reg <= poll_cnt_reg + 32'h1;
            if ((cyc_rdata[`POLL_DONE_BIT] && rb_s2) || cyc_rdata[`POLL_ERR_BIT]) begin
              // error bit is judged even when the done bit is also up
              resp_crc_fail <= cyc_rdata[`POLL_ERR_BIT];
              resp_data <= cyc_rdata;
              state_reg <= s_resp;
            end else if (poll_cnt_reg == 32'(POLL_LIMIT)) begin
              resp_timeout <= 1'b1;
              state_reg <= s_resp;
            end else begin
              cyc_start_reg <= 1'b1;
            end
          end
        end
        s_resp: begin
          resp_valid <= 1'b1;
          state_reg <= s_idle;
        end
        default: state_reg <= s_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: id_crc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module id_crc_checker
  import flash_cmd_pkg::*;
#(parameter int ADDR_W = 26) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire op_e cmd_op,
  input wire logic [31:0] cmd_start_addr,
  input wire logic [31:0] cmd_stop_addr,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire logic resp_crc_fail,
  input wire logic resp_refused,
  input wire logic resp_timeout,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  wire bad_range = take && cmd_op == op_crc_range && cmd_stop_addr <= cmd_start_addr;
  strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
    else $error("strobes overlap");
  strobe_cs_a: assert property (!(read_strobe_n && write_strobe_n) |-> !chip_select_n)
    else $error("strobe without select");
  drive_dir_a: assert property (dq_oe |-> read_strobe_n)
    else $error("driving during read");
  write_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*3])
    else $error("short write");
  write_hold_a: assert property (!write_strobe_n ##1 !write_strobe_n |-> $stable(dq_out) && $stable(addr_out))
    else $error("write data moved");
  read_width_a: assert property ($fell(read_strobe_n) |-> (!read_strobe_n && !dq_oe)[*5])
    else $error("short read");
  range_refuse_a: assert property (bad_range |=> write_strobe_n throughout (##[0:1] resp_valid && resp_refused))
    else $error("bad range not refused");
  none_refuse_a: assert property (take && cmd_op == op_none |-> ##[1:2] resp_valid && resp_refused)
    else $error("empty op not refused");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("long response");
  ready_drop_a: assert property (take |=> !cmd_ready)
    else $error("ready while busy");
  cover property (take && cmd_op == op_crc_range);
  cover property (resp_valid && resp_crc_fail);
  cover property (resp_valid && resp_timeout);
endmodule
bind flash_id_crc_ctrl id_crc_checker #(.ADDR_W(ADDR_W)) chk (
  .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_start_addr(cmd_start_addr), .cmd_stop_addr(cmd_stop_addr), .cmd_ready(cmd_ready),
  .resp_valid(resp_valid), .resp_crc_fail(resp_crc_fail), .resp_refused(resp_refused),
  .resp_timeout(resp_timeout), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .addr_out(addr_out), .dq_out(dq_out), .dq_oe(dq_oe)
);
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_cmd_pkg::*;
  logic mclk = 0, rst = 1, cmd_valid = 0, byte_mode = 0, prog_busy = 0, slow = 0;
  op_e cmd_op = op_none;
  id_sel_e cmd_id_sel = rd_manuf;
  logic [25:0] cmd_addr = '0;
  logic [31:0] cmd_start_addr = '0, cmd_stop_addr = '0;
  logic [63:0] cmd_expected_crc = '0;
  logic cmd_ready, resp_valid, resp_crc_fail, resp_refused, resp_timeout, byte_lsb_address, dq_oe, ready_busy_pin;
  logic chip_select_n, read_strobe_n, write_strobe_n;
  logic [25:0] addr_out;
  logic [15:0] resp_data, dq_out, dq_in;
  logic [19:0] expq[$];
  logic [19:0] e;
  int num_errors = 0, cmp_count = 0;
  // ids match the model's arbitrary values
  id_sel_e ids[7] = '{rd_manuf, rd_dev1, rd_dev2, rd_dev3, rd_extlock, rd_prot, rd_prot};
  logic [25:0] ida[7] = '{26'h0, 26'h0, 26'h0, 26'h0, 26'h0, 26'h30000, 26'h20000};
  logic [15:0] idv[7] = '{16'h00c1, 16'h1a01, 16'h1a02, 16'h1a03, 16'h0009, 16'h0001, 16'h0000};
  flash_id_crc_ctrl #(.POLL_LIMIT(16)) uut (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_id_sel(cmd_id_sel),
    .cmd_addr(cmd_addr), .cmd_start_addr(cmd_start_addr), .cmd_stop_addr(cmd_stop_addr),
    .cmd_expected_crc(cmd_expected_crc), .byte_mode(byte_mode), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_crc_fail(resp_crc_fail),
    .resp_refused(resp_refused), .resp_timeout(resp_timeout), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr_out(addr_out),
    .byte_lsb_address(byte_lsb_address), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ready_busy_pin(ready_busy_pin)
  );
  flash_dev_model dev (
    .mclk(mclk), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .addr_out(addr_out), .dq_out(dq_out), .prog_busy(prog_busy),
    .slow(slow), .byte_mode(byte_mode), .byte_lsb_address(byte_lsb_address), .dq_in(dq_in),
    .ready_busy_pin(ready_busy_pin)
  );
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // expectation bits: check data, fail, refused, timeout, data
  task automatic issue(input op_e op, input id_sel_e sel, input logic [25:0] a, input logic [31:0] s,
      input logic [31:0] t, input logic [63:0] c, input logic [19:0] exp);
    int i;
    expq.push_back(exp);
    cmd_op <= op;
    cmd_id_sel <= sel;
    cmd_addr <= a;
    cmd_start_addr <= s;
    cmd_stop_addr <= t;
    cmd_expected_crc <= c;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_valid <= 1'b0;
    i = 0;
    while (expq.size() > 0 && i < 5000) begin
      @(posedge mclk);
      i++;
    end
    if (expq.size() > 0) begin
      num_errors++;
      summarize();
    end
    @(posedge mclk);
  endtask
  always @(posedge mclk) if (resp_valid === 1'b1) begin
    if (expq.size() == 0) check(19'h1, 19'h0);
    else begin
      e = expq.pop_front();
      // timeout leaves the verdict open, so fail is not judged then
      check({resp_crc_fail, resp_refused, resp_timeout, resp_data} & {~e[16], 2'b11, {16{e[19]}}},
        e[18:0] & {~e[16], 2'b11, {16{e[19]}}});
    end
  end
  initial begin
    logic [31:0] s, t;
    logic [63:0] c;
    void'($urandom(18));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    prog_busy <= 1'b1;
    repeat (6) @(posedge mclk);
    issue(op_autosel, rd_manuf, 0, 0, 0, 0, {4'b0010, 16'h0});
    issue(op_suspend, rd_manuf, 0, 0, 0, 0, 20'h0);
    issue(op_autosel, rd_manuf, 0, 0, 0, 0, 20'h0);
    for (int k = 0; k < 7; k++) issue(op_read_id, ids[k], ida[k], 0, 0, 0, {4'b1000, idv[k]});
    issue(op_reset, rd_manuf, 0, 0, 0, 0, 20'h0);
    issue(op_read_id, rd_manuf, 0, 0, 0, 0, {4'b1000, 16'h5b5a});
    prog_busy <= 1'b0;
    c = dev.crc(0, 63);
    issue(op_crc_chip, rd_manuf, 0, 0, 0, c, 20'h0);
    issue(op_crc_chip, rd_manuf, 0, 0, 0, c ^ 64'h1, {4'b0100, 16'h0});
    repeat (3) begin
      s = $urandom_range(30);
      t = s + 1 + $urandom_range(30);
      issue(op_crc_range, rd_manuf, 0, s, t, dev.crc(s, t), 20'h0);
    end
    byte_mode <= 1'b1;
    issue(op_crc_chip, rd_manuf, 0, 0, 0, c, 20'h0);
    s = $urandom_range(30);
    t = s + 1 + $urandom_range(30);
    issue(op_crc_range, rd_manuf, 0, s, t, dev.crc(s, t) ^ 64'h100, {4'b0100, 16'h0});
    byte_mode <= 1'b0;
    issue(op_crc_range, rd_manuf, 0, 5, 5, 0, {4'b0010, 16'h0});
    issue(op_none, rd_manuf, 0, 0, 0, 0, {4'b0010, 16'h0});
    slow <= 1'b1;
    issue(op_crc_chip, rd_manuf, 0, 0, 0, c, {4'b0001, 16'h0});
    summarize();
  end
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
